// ===== hdl/serial_divider.sv
module serial_divider #(
    parameter int NUM_W = 32,
    parameter int DEN_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // request
    input wire logic start,
    input wire logic [NUM_W-1:0] dividend,
    input wire logic [DEN_W-1:0] divisor,
    // answer
    output logic busy,
    output logic done,
    output logic [NUM_W-1:0] quotient
);

    typedef struct packed {
        logic busy;
        logic done;
        logic [7:0] count;
        logic [DEN_W:0] rem;
        logic [NUM_W-1:0] quo;
        logic [DEN_W-1:0] den;
    } div_state_t;

    div_state_t q;
    div_state_t d;

    // restoring division, one quotient bit per clock
    always_comb begin
        logic [DEN_W:0] trial;
        trial = '0;
        d = q;
        d.done = 1'b0;
        if (q.busy) begin
            trial = {q.rem[DEN_W-1:0], q.quo[NUM_W-1]};
            d.quo = {q.quo[NUM_W-2:0], 1'b0};
            if (trial >= {1'b0, q.den}) begin
                d.rem = trial - {1'b0, q.den};
                d.quo[0] = 1'b1;
            end else begin
                d.rem = trial;
            end
            d.count = q.count - 8'h01;
            if (q.count == 8'h01) begin
                d.busy = 1'b0;
                d.done = 1'b1;
            end
        end else if (start) begin
            d.busy = 1'b1;
            d.rem = '0;
            d.quo = dividend;
            d.den = divisor;
            d.count = 8'(NUM_W);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign busy = q.busy;
    assign done = q.done;
    assign quotient = q.quo;

endmodule

// ===== hdl/speed_ref_pkg.sv
package speed_ref_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_GAIN = 8'h04;
    localparam logic [7:0] ADDR_ACCEL = 8'h08;
    localparam logic [7:0] ADDR_DECEL = 8'h0c;
    localparam logic [7:0] ADDR_OFFSET = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h20;
    localparam logic [7:0] ADDR_SPEED = 8'h24;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_WRITE_PERMIT = 0;
    localparam int CTRL_AUTO_START = 1;
    localparam int CTRL_PARAM_INIT = 2;
    localparam int CTRL_HOST_POS_LOOP = 3;

    // status register fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_SERVO_ON = 1;
    localparam int STAT_MAIN_POWER = 2;
    localparam int STAT_RAMPING = 3;

    // interrupt bits
    localparam int IRQ_W = 3;
    localparam int IRQ_AUTO_DONE = 0;
    localparam int IRQ_NOT_PERMITTED = 1;
    localparam int IRQ_MANUAL_DONE = 2;

    // ------------------------------------------------------------
    // settings: ranges and defaults
    // ------------------------------------------------------------
    localparam logic [11:0] GAIN_MIN = 12'h096;
    localparam logic [11:0] GAIN_MAX = 12'hbb8;
    localparam logic [11:0] GAIN_DEFAULT = 12'h258;
    localparam logic [13:0] RAMP_TIME_MAX = 14'h2710;
    localparam logic [13:0] RAMP_TIME_DEFAULT = 14'h0000;

    // gain counts 0.01 V, reference counts 1 mV
    localparam logic [3:0] MV_PER_GAIN_STEP = 4'ha;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int RAMP_UNIT_NS = 1000000;
    localparam int CYCLES_PER_MS = RAMP_UNIT_NS / CLK_PERIOD_NS;

endpackage

// ===== hdl/speed_reference_conditioner.sv
// Decided for this implementation: the APB slave port and the address map.
module speed_reference_conditioner #(
    parameter int REF_W = 16,
    parameter int SPEED_W = 16,
    parameter int RATED_SCALE = 4096,
    parameter int MAX_SPEED = 8192,
    parameter int AVG_LOG2 = 4,
    parameter int CYCLES_PER_MS = speed_ref_pkg::CYCLES_PER_MS
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sampled speed reference, mV against reference_signal_ground
    input wire logic signed [REF_W-1:0] refSample,
    input wire logic refValid,
    // pins from the host and the power stage
    input wire logic servoOnPin,
    input wire logic mainPowerPin,
    // non-volatile offset storage
    input wire logic nvLoad,
    input wire logic signed [REF_W-1:0] nvLoadData,
    output logic nvStore,
    output logic signed [REF_W-1:0] nvData,
    // speed command and interrupt
    output logic signed [SPEED_W-1:0] speedCmd,
    output logic irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DIVIDE = 2'b01,
        ST_AVERAGE = 2'b10
    } mode_t;

    typedef struct packed {
        mode_t mode;
        logic writePermit;
        logic hostPosLoop;
        logic [11:0] gain;
        logic [13:0] accelTime;
        logic [13:0] decelTime;
        logic signed [REF_W-1:0] offset;
        logic [speed_ref_pkg::IRQ_W-1:0] irqStat;
        logic [speed_ref_pkg::IRQ_W-1:0] irqEn;
        logic [31:0] rdata;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] sync3;
        logic [1:0] pinLevel;
        logic [AVG_LOG2:0] avgCount;
        logic signed [REF_W+AVG_LOG2:0] avgSum;
        logic negative;
        logic signed [SPEED_W-1:0] target;
        logic signed [SPEED_W-1:0] speed;
        logic [31:0] rampAcc;
        logic nvStore;
        logic signed [REF_W-1:0] nvData;
    } cond_state_t;

    cond_state_t q;
    cond_state_t d;

    localparam logic signed [SPEED_W-1:0] SPEED_LIMIT = SPEED_W'(MAX_SPEED);
    localparam logic [AVG_LOG2:0] AVG_SAMPLES = (AVG_LOG2+1)'(1 << AVG_LOG2);

    // ------------------------------------------------------------
    // divider for voltage over gain
    // ------------------------------------------------------------
    logic divStart;
    logic divBusy;
    logic divDone;
    logic [31:0] divDividend;
    logic [15:0] divDivisor;
    logic [31:0] divQuotient;

    serial_divider #(
        .NUM_W(32),
        .DEN_W(16)
    ) u_div (
        .clk(clk),
        .arst_n(arst_n),
        .start(divStart),
        .dividend(divDividend),
        .divisor(divDivisor),
        .busy(divBusy),
        .done(divDone),
        .quotient(divQuotient)
    );

    // ------------------------------------------------------------
    // combinational helpers
    // ------------------------------------------------------------
    logic servoOn;
    logic mainPower;
    logic signed [REF_W:0] corrected;
    logic [REF_W:0] magnitude;
    logic apbWrite;
    logic apbSetup;
    logic mapped;

    assign servoOn = q.pinLevel[0];
    assign mainPower = q.pinLevel[1];

    assign corrected = (REF_W+1)'(refSample) - (REF_W+1)'(q.offset);
    assign magnitude = corrected[REF_W] ? (REF_W+1)'(-corrected) : (REF_W+1)'(corrected);

    assign divDividend = 32'(magnitude) * 32'(RATED_SCALE);
    assign divDivisor = 16'(q.gain) * 16'(speed_ref_pkg::MV_PER_GAIN_STEP);
    assign divStart = (q.mode == ST_IDLE) && refValid && !divBusy;

    assign apbWrite = psel && penable && pwrite;
    assign apbSetup = psel && !penable;
    assign mapped = (paddr <= speed_ref_pkg::ADDR_SPEED) && (paddr[1:0] == 2'b00);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [speed_ref_pkg::IRQ_W-1:0] events;
        logic [31:0] threshold;
        logic [31:0] accNext;
        logic [13:0] rampTime;
        logic away;
        logic signed [SPEED_W-1:0] scaled;
        events = '0;
        threshold = '0;
        accNext = '0;
        rampTime = '0;
        away = 1'b0;
        scaled = '0;
        d = q;
        d.nvStore = 1'b0;

        // pins: three stages, accept once stage two and three agree
        d.sync1 = {mainPowerPin, servoOnPin};
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        for (int i = 0; i < 2; i++) begin
            if (q.sync2[i] == q.sync3[i]) begin
                d.pinLevel[i] = q.sync3[i];
            end
        end

        // restore offset from storage after power up
        if (nvLoad) begin
            d.offset = nvLoadData;
        end

        // register writes
        if (apbWrite) begin
            case (paddr)
                speed_ref_pkg::ADDR_CTRL: begin
                    d.writePermit = pwdata[speed_ref_pkg::CTRL_WRITE_PERMIT];
                    d.hostPosLoop = pwdata[speed_ref_pkg::CTRL_HOST_POS_LOOP];
                    if (pwdata[speed_ref_pkg::CTRL_PARAM_INIT]) begin
                        if (q.writePermit) begin
                            d.gain = speed_ref_pkg::GAIN_DEFAULT;
                            d.accelTime = speed_ref_pkg::RAMP_TIME_DEFAULT;
                            d.decelTime = speed_ref_pkg::RAMP_TIME_DEFAULT;
                        end else begin
                            events[speed_ref_pkg::IRQ_NOT_PERMITTED] = 1'b1;
                        end
                    end
                    if (pwdata[speed_ref_pkg::CTRL_AUTO_START]) begin
                        if (q.writePermit && !servoOn && !q.hostPosLoop
                                && q.mode == ST_IDLE && !divBusy) begin
                            d.mode = ST_AVERAGE;
                            d.avgCount = '0;
                            d.avgSum = '0;
                        end else begin
                            events[speed_ref_pkg::IRQ_NOT_PERMITTED] = 1'b1;
                        end
                    end
                end
                speed_ref_pkg::ADDR_GAIN: begin
                    if (pwdata[11:0] >= speed_ref_pkg::GAIN_MIN
                            && pwdata[11:0] <= speed_ref_pkg::GAIN_MAX
                            && pwdata[31:12] == '0) begin
                        d.gain = pwdata[11:0];
                    end
                end
                speed_ref_pkg::ADDR_ACCEL: begin
                    if (pwdata[13:0] <= speed_ref_pkg::RAMP_TIME_MAX && pwdata[31:14] == '0) begin
                        d.accelTime = pwdata[13:0];
                    end
                end
                speed_ref_pkg::ADDR_DECEL: begin
                    if (pwdata[13:0] <= speed_ref_pkg::RAMP_TIME_MAX && pwdata[31:14] == '0) begin
                        d.decelTime = pwdata[13:0];
                    end
                end
                speed_ref_pkg::ADDR_OFFSET: begin
                    if (q.writePermit && mainPower && q.mode != ST_AVERAGE) begin
                        d.offset = pwdata[REF_W-1:0];
                        d.nvStore = 1'b1;
                        d.nvData = pwdata[REF_W-1:0];
                        events[speed_ref_pkg::IRQ_MANUAL_DONE] = 1'b1;
                    end else begin
                        events[speed_ref_pkg::IRQ_NOT_PERMITTED] = 1'b1;
                    end
                end
                speed_ref_pkg::ADDR_IRQ_EN: begin
                    d.irqEn = pwdata[speed_ref_pkg::IRQ_W-1:0];
                end
                speed_ref_pkg::ADDR_IRQ_CLR: begin
                    d.irqStat = q.irqStat & ~pwdata[speed_ref_pkg::IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // reference path
        case (q.mode)
            ST_IDLE: begin
                if (divStart) begin
                    d.mode = ST_DIVIDE;
                    d.negative = corrected[REF_W];
                end
            end
            ST_DIVIDE: begin
                if (divDone) begin
                    d.mode = ST_IDLE;
                    if (divQuotient > 32'(MAX_SPEED)) begin
                        scaled = SPEED_LIMIT;
                    end else begin
                        scaled = SPEED_W'(divQuotient);
                    end
                    d.target = q.negative ? -scaled : scaled;
                end
            end
            ST_AVERAGE: begin
                // relies on 0 V at input during averaging
                // average raw samples as the offset
                if (refValid) begin
                    d.avgSum = q.avgSum + (REF_W+AVG_LOG2+1)'(refSample);
                    d.avgCount = q.avgCount + (AVG_LOG2+1)'(1);
                end
                if (q.avgCount == AVG_SAMPLES) begin
                    d.mode = ST_IDLE;
                    d.offset = REF_W'(q.avgSum >>> AVG_LOG2);
                    d.nvStore = 1'b1;
                    d.nvData = REF_W'(q.avgSum >>> AVG_LOG2);
                    events[speed_ref_pkg::IRQ_AUTO_DONE] = 1'b1;
                end
            end
            default: begin
                d.mode = ST_IDLE;
            end
        endcase

        // soft start: moving away from zero accelerates, toward zero decelerates
        if (q.target > q.speed) begin
            away = q.speed >= 0;
        end else begin
            away = q.speed <= 0;
        end
        rampTime = away ? q.accelTime : q.decelTime;
        // threshold per unit step gives constant slope
        threshold = 32'(rampTime) * 32'(CYCLES_PER_MS);
        accNext = q.rampAcc + 32'(MAX_SPEED);
        if (q.target == q.speed) begin
            d.rampAcc = '0;
        end else if (rampTime == '0) begin
            // zero time jumps straight to target
            d.speed = q.target;
            d.rampAcc = '0;
        end else if (accNext >= threshold) begin
            d.rampAcc = accNext - threshold;
            d.speed = (q.target > q.speed) ? q.speed + SPEED_W'(1) : q.speed - SPEED_W'(1);
        end else begin
            d.rampAcc = accNext;
        end

        // sticky events, set wins over clear
        d.irqStat = d.irqStat | events;

        // read data captured in the setup phase
        if (apbSetup) begin
            case (paddr)
                speed_ref_pkg::ADDR_CTRL: begin
                    d.rdata = '0;
                    d.rdata[speed_ref_pkg::CTRL_WRITE_PERMIT] = q.writePermit;
                    d.rdata[speed_ref_pkg::CTRL_HOST_POS_LOOP] = q.hostPosLoop;
                end
                speed_ref_pkg::ADDR_GAIN: d.rdata = 32'(q.gain);
                speed_ref_pkg::ADDR_ACCEL: d.rdata = 32'(q.accelTime);
                speed_ref_pkg::ADDR_DECEL: d.rdata = 32'(q.decelTime);
                speed_ref_pkg::ADDR_OFFSET: d.rdata = 32'(signed'(q.offset));
                speed_ref_pkg::ADDR_STATUS: begin
                    d.rdata = '0;
                    d.rdata[speed_ref_pkg::STAT_BUSY] = q.mode == ST_AVERAGE;
                    d.rdata[speed_ref_pkg::STAT_SERVO_ON] = servoOn;
                    d.rdata[speed_ref_pkg::STAT_MAIN_POWER] = mainPower;
                    d.rdata[speed_ref_pkg::STAT_RAMPING] = q.speed != q.target;
                end
                speed_ref_pkg::ADDR_IRQ_STAT: d.rdata = 32'(q.irqStat);
                speed_ref_pkg::ADDR_IRQ_EN: d.rdata = 32'(q.irqEn);
                speed_ref_pkg::ADDR_SPEED: d.rdata = 32'(signed'(q.speed));
                default: d.rdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
            q.gain <= speed_ref_pkg::GAIN_DEFAULT;
            q.accelTime <= speed_ref_pkg::RAMP_TIME_DEFAULT;
            q.decelTime <= speed_ref_pkg::RAMP_TIME_DEFAULT;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // zero wait states keep the bus simple; read data is set up a cycle early
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = q.rdata;
    assign nvStore = q.nvStore;
    assign nvData = q.nvData;
    assign speedCmd = q.speed;
    assign irq = |(q.irqStat & q.irqEn);

endmodule

// ===== test/host_ref_source.sv
module host_ref_source #(
    parameter int REF_W = 16
) (
    // clock
    input wire logic clk,
    // reference and servo-on toward the drive
    output logic signed [REF_W-1:0] refSample,
    output logic refValid,
    output logic servoOnPin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic signed [REF_W-1:0] level = '0;

    // converter value is only meaningful with valid, so show garbage otherwise
    assign refSample = refValid ? level : ~level;

    initial begin
        refValid = 1'b0;
        servoOnPin = 1'b0;
    end

    // one sample of mv millivolts
    task automatic sample(input logic signed [REF_W-1:0] mv);
        @(posedge clk);
        level <= mv;
        refValid <= 1'b1;
        @(posedge clk);
        refValid <= 1'b0;
    endtask

    task automatic servo(input logic on);
        @(posedge clk);
        servoOnPin <= on;
    endtask

    task automatic hold_zero(input logic signed [REF_W-1:0] residual, input int n);
        servo(1'b0);
        repeat (n) begin
            sample(residual);
            repeat (40) @(posedge clk);
        end
    endtask
endmodule

// ===== test/speed_ref_monitor.sv
module speed_ref_monitor #(
    parameter int REF_W = 16,
    parameter int SPEED_W = 16,
    parameter int MAX_SPEED = 8192
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and outputs
    input wire logic servoOnPin,
    input wire logic mainPowerPin,
    input wire logic nvStore,
    input wire logic signed [REF_W-1:0] nvData,
    input wire logic signed [SPEED_W-1:0] speedCmd,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // irq may only drop after software touched clear or enable
    wire logic irqTouch = psel && penable && pwrite
        && (paddr == speed_ref_pkg::ADDR_IRQ_CLR || paddr == speed_ref_pkg::ADDR_IRQ_EN);

    // --------------------------------------------------------
    // register write steps
    // --------------------------------------------------------
    sequence s_wr(logic [7:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence
    sequence s_ctrl(int b);
        s_wr(speed_ref_pkg::ADDR_CTRL) ##0 pwdata[b];
    endsequence

    a_ready_always: assert property (pready)
        else $error("pready low");
    a_unmapped_error: assert property (psel && penable
        |-> pslverr == (paddr > 8'h24 || paddr[1:0] != 2'h0))
        else $error("pslverr wrong");
    a_store_pulse: assert property (nvStore |=> !nvStore)
        else $error("store pulse too long");
    a_manual_data: assert property (s_wr(speed_ref_pkg::ADDR_OFFSET) ##1 nvStore
        |-> nvData == $past(pwdata[REF_W-1:0]))
        else $error("stored offset differs from written");
    a_nopower_refuse: assert property ((!mainPowerPin)[*5] ##0
        s_wr(speed_ref_pkg::ADDR_OFFSET) |=> !nvStore)
        else $error("offset stored without main power");
    a_servo_refuse: assert property (servoOnPin[*5] ##0 s_ctrl(1) |=> !nvStore[*8])
        else $error("auto adjust ran with servo on");
    a_init_keep: assert property (s_ctrl(2) |=> $stable(nvData)[*2])
        else $error("init touched offset");
    a_speed_clamp: assert property (speedCmd <= MAX_SPEED && speedCmd >= -MAX_SPEED)
        else $error("speed out of range");
    a_irq_release: assert property ($fell(irq) |-> $past(irqTouch))
        else $error("irq dropped on its own");
endmodule

bind speed_reference_conditioner speed_ref_monitor #(
    .REF_W(REF_W), .SPEED_W(SPEED_W), .MAX_SPEED(MAX_SPEED)
) i_mon (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .servoOnPin(servoOnPin), .mainPowerPin(mainPowerPin), .nvStore(nvStore),
    .nvData(nvData), .speedCmd(speedCmd), .irq(irq)
);

// ===== test/speed_reference_conditioner_tb.sv
module speed_reference_conditioner_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic signed [15:0] refSample;
    logic refValid;
    logic servoOnPin;
    logic mainPowerPin = 1'b0;
    logic nvLoad = 1'b0;
    logic signed [15:0] nvLoadData = 16'h0000;
    logic nvStore;
    logic signed [15:0] nvData;
    logic signed [15:0] speedCmd;
    logic irq;
    int bad_count = 0;
    int checked = 0;

    always #2 clk = ~clk;

    // short ms and small speed scale keep ramps a few hundred cycles
    speed_reference_conditioner #(.RATED_SCALE(128), .MAX_SPEED(256), .AVG_LOG2(2),
        .CYCLES_PER_MS(4)) i_dut (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .refSample(refSample), .refValid(refValid),
        .servoOnPin(servoOnPin), .mainPowerPin(mainPowerPin), .nvLoad(nvLoad),
        .nvLoadData(nvLoadData), .nvStore(nvStore), .nvData(nvData),
        .speedCmd(speedCmd), .irq(irq));

    host_ref_source i_host (.clk(clk), .refSample(refSample), .refValid(refValid),
        .servoOnPin(servoOnPin));

    // --------------------------------------------------------
    // bench tasks
    // --------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (bad_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // one apb transfer; request held until pready is seen
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask

    // out-of-range writes are dropped, the limits themselves land
    task automatic lim(input logic [7:0] a, input int lo, input int hi, input int dflt);
        wr(a, lo - 1);
        rd(a, dflt);
        wr(a, hi + 1);
        rd(a, dflt);
        wr(a, lo);
        rd(a, lo);
        wr(a, hi);
        rd(a, hi);
        wr(a, dflt);
    endtask

    task automatic sp(input int mv, input int exp);
        i_host.sample(16'(mv));
        repeat (40) @(posedge clk);
        check(32'(speedCmd), exp);
    endtask

    // one-cycle load of a stored offset, as after power up
    task automatic restore(input logic signed [15:0] v);
        @(posedge clk);
        nvLoad <= 1'b1;
        nvLoadData <= v;
        @(posedge clk);
        nvLoad <= 1'b0;
    endtask

    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end

    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd(speed_ref_pkg::ADDR_GAIN, 600);
        rd(speed_ref_pkg::ADDR_ACCEL, 0);
        rd(speed_ref_pkg::ADDR_DECEL, 0);
        rd(speed_ref_pkg::ADDR_OFFSET, 0);
        rd(8'h28, 0);
        rd(8'h06, 0);
        lim(speed_ref_pkg::ADDR_GAIN, 150, 3000, 600);
        lim(speed_ref_pkg::ADDR_ACCEL, 0, 10000, 0);
        lim(speed_ref_pkg::ADDR_DECEL, 0, 10000, 0);
        // power-up restore of a stored offset
        restore(16'sd55);
        rd(speed_ref_pkg::ADDR_OFFSET, 55);
        sp(6055, 128);
        sp(-2945, -64);
        sp(1055, 21);
        wr(speed_ref_pkg::ADDR_GAIN, 3000);
        sp(6055, 25);
        // manual offset refused without main power, masked then enabled irq
        wr(speed_ref_pkg::ADDR_CTRL, 1);
        wr(speed_ref_pkg::ADDR_OFFSET, 0);
        rd(speed_ref_pkg::ADDR_IRQ_STAT, 2);
        check(irq, 0);
        wr(speed_ref_pkg::ADDR_IRQ_EN, 7);
        // irq follows the write one edge later, look once it has settled
        @(negedge clk);
        check(irq, 1);
        wr(speed_ref_pkg::ADDR_IRQ_CLR, 2);
        @(negedge clk);
        check(irq, 0);
        rd(speed_ref_pkg::ADDR_OFFSET, 55);
        mainPowerPin <= 1'b1;
        repeat (6) @(posedge clk);
        wr(speed_ref_pkg::ADDR_OFFSET, 30);
        rd(speed_ref_pkg::ADDR_OFFSET, 30);
        check(nvData, 30);
        rd(speed_ref_pkg::ADDR_IRQ_STAT, 4);
        wr(speed_ref_pkg::ADDR_CTRL, 0);
        wr(speed_ref_pkg::ADDR_OFFSET, 9);
        rd(speed_ref_pkg::ADDR_OFFSET, 30);
        // init restores gain but keeps offset
        wr(speed_ref_pkg::ADDR_CTRL, 1);
        wr(speed_ref_pkg::ADDR_CTRL, 5);
        rd(speed_ref_pkg::ADDR_GAIN, 600);
        rd(speed_ref_pkg::ADDR_OFFSET, 30);
        rd(speed_ref_pkg::ADDR_CTRL, 1);
        rd(speed_ref_pkg::ADDR_STATUS, 4);
        rd(speed_ref_pkg::ADDR_SPEED, 25);
        // auto adjust refused: servo on, no permit, host position loop
        for (int i = 0; i < 3; i++) begin
            wr(speed_ref_pkg::ADDR_IRQ_CLR, 7);
            i_host.servo(i == 0);
            // permit and loop flags act from the next write on
            if (i != 0) wr(speed_ref_pkg::ADDR_CTRL, (i == 1) ? 0 : 9);
            repeat (6) @(posedge clk);
            wr(speed_ref_pkg::ADDR_CTRL, (i == 0) ? 3 : ((i == 1) ? 2 : 11));
            rd(speed_ref_pkg::ADDR_IRQ_STAT, 2);
        end
        wr(speed_ref_pkg::ADDR_IRQ_CLR, 7);
        wr(speed_ref_pkg::ADDR_CTRL, 1);
        wr(speed_ref_pkg::ADDR_CTRL, 3);
        i_host.hold_zero(16'sd20, 4);
        rd(speed_ref_pkg::ADDR_OFFSET, 20);
        check(nvData, 20);
        rd(speed_ref_pkg::ADDR_IRQ_STAT, 1);
        // ramps: accel step every 2 cycles, decel every cycle
        wr(speed_ref_pkg::ADDR_OFFSET, 0);
        sp(0, 0);
        wr(speed_ref_pkg::ADDR_ACCEL, 128);
        wr(speed_ref_pkg::ADDR_DECEL, 64);
        i_host.sample(16'sd6000);
        repeat (140) @(posedge clk);
        check(speedCmd > 0 && speedCmd < 128, 1);
        repeat (140) @(posedge clk);
        check(speedCmd > 105 && speedCmd < 128, 1);
        repeat (60) @(posedge clk);
        check(32'(speedCmd), 128);
        i_host.sample(16'sd0);
        repeat (80) @(posedge clk);
        check(speedCmd > 30 && speedCmd < 120, 1);
        repeat (100) @(posedge clk);
        check(32'(speedCmd), 0);
        wrap_up();
    end
endmodule
